// *** core/dig_ctrl_map.vh ***
// constants for the device init and global control block
`ifndef DIG_CTRL_MAP_VH
`define DIG_CTRL_MAP_VH
`define DIG_ST_IDLE    3'h0
`define DIG_ST_CONFIG  3'h1
`define DIG_ST_INIT    3'h2
`define DIG_ST_USER    3'h3
`define DIG_OPT_W      4
`define DIG_OPT_STCLK  0
`define DIG_OPT_DONE   1
`define DIG_OPT_OE     2
`define DIG_OPT_CLR    3
`define DIG_OPT_RESET  4'h0
`define DIG_INIT_CYC   16
`define DIG_STCLK_IDLE 3'h7
`endif

// *** core/dig_pin_mux.v ***
// one optional control pin: dedicated function or user i/o
`timescale 1ns/1ps
module dig_pin_mux (
  input  wire sys_clk,
  input  wire reset,
  input  wire option_en,
  input  wire in_config,
  input  wire pin_in,
  input  wire user_out,
  input  wire user_oe,
  input  wire ded_out,
  input  wire ded_oe,
  output reg  pin_out_r,
  output reg  pin_oe_r,
  output reg  pin_pullup_r,
  output reg  user_in_r
);
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pin_out_r    <= 1'b0;
      pin_oe_r     <= 1'b0;
      pin_pullup_r <= 1'b1;
      user_in_r    <= 1'b0;
    end else if (option_en) begin
      pin_out_r    <= ded_out;
      pin_oe_r     <= ded_oe;
      pin_pullup_r <= 1'b0;
      user_in_r    <= 1'b0;
    end else if (in_config) begin
      pin_out_r    <= 1'b0;
      pin_oe_r     <= 1'b0;
      pin_pullup_r <= 1'b1;
      user_in_r    <= 1'b0;
    end else begin
      pin_out_r    <= user_out;
      pin_oe_r     <= user_oe;
      pin_pullup_r <= 1'b0;
      user_in_r    <= pin_in;
    end
  end
endmodule

// *** core/dig_ctrl.v ***
// device init sequencing and global override pins
//
// Overview of operation
// - disabled optional pin is user i/o, tri-stated with pull-up during configuration
// - start-up clock option makes initialization count on external clock edges
// - init-done pin undriven while config request low and at config start
// - init-done driven low once its option arrives in first frame
// - init-done released when initialization ends; user mode entered then
// - global output enable low tri-states user i/o only when enabled
// - global clear low clears the user-side input stage when enabled
`timescale 1ns/1ps
`include "dig_ctrl_map.vh"
module dig_ctrl #(
  parameter INIT_CYC = `DIG_INIT_CYC
) (
  input  wire                 sys_clk,
  input  wire                 reset,
  input  wire                 config_request_n,
  input  wire                 frame_valid,
  input  wire                 frame_first,
  input  wire [`DIG_OPT_W-1:0] frame_opts,
  input  wire                 config_end,
  input  wire [`DIG_OPT_W-1:0] pin_in,
  input  wire [`DIG_OPT_W-1:0] user_out,
  input  wire [`DIG_OPT_W-1:0] user_oe,
  output reg  [`DIG_OPT_W-1:0] pin_out_r,
  output reg  [`DIG_OPT_W-1:0] pin_oe_r,
  output reg  [`DIG_OPT_W-1:0] pin_pullup_r,
  output reg  [`DIG_OPT_W-1:0] user_in_r,
  output reg  [`DIG_OPT_W-1:0] opts_r,
  output reg                  in_config_r,
  output reg                  user_mode_r,
  output reg                  io_tristate_r,
  output reg                  reg_clear_r
);
  reg  [2:0]            state_r;
  reg  [2:0]            state_nxt;
  reg  [15:0]           init_cnt_r;
  reg  [15:0]           init_cnt_nxt;
  reg  [2:0]            stclk_sync_r;
  reg  [`DIG_OPT_W-1:0] opts_nxt;
  reg                   user_arm_r;

  wire                  stclk_rise;
  wire [`DIG_OPT_W-1:0] m_out;
  wire [`DIG_OPT_W-1:0] m_oe;
  wire [`DIG_OPT_W-1:0] m_pu;
  wire [`DIG_OPT_W-1:0] m_in;
  wire [`DIG_OPT_W-1:0] m_in_unused;
  wire [`DIG_OPT_W-1:0] ded_oe;
  wire                  done_drive;
  wire                  init_tick;
  wire                  init_last;
  wire                  cfg_phase;
  wire                  cfg_next;
  wire                  pins_held;
  wire                  first_frame;

  // configuration or initialization in progress
  function cfg_state;
    input [2:0] st;
    begin
      cfg_state = (st == `DIG_ST_CONFIG) || (st == `DIG_ST_INIT);
    end
  endfunction

  // state sits in user mode
  function user_state;
    input [2:0] st;
    begin
      user_state = st == `DIG_ST_USER;
    end
  endfunction

  // override option on and its pin pulled low
  function override_low;
    input en;
    input lvl;
    begin
      override_low = en && !lvl;
    end
  endfunction

  assign cfg_phase   = cfg_state(state_r);
  assign cfg_next    = cfg_state(state_nxt);
  // user pins float until user mode, and again on a new request
  assign pins_held   = !user_state(state_r) || !config_request_n;
  assign first_frame = (state_r == `DIG_ST_CONFIG) && frame_valid && frame_first;
  assign stclk_rise  = stclk_sync_r[1] & ~stclk_sync_r[2];
  assign init_tick   = opts_r[`DIG_OPT_STCLK] ? stclk_rise : 1'b1;
  assign init_last   = init_cnt_r == (INIT_CYC[15:0] - 16'h0001);
  // open drain: drive low only between option arrival and init end
  assign done_drive  = cfg_phase && opts_r[`DIG_OPT_DONE] && config_request_n;
  assign ded_oe      = {`DIG_OPT_W{1'b0}} | ({{(`DIG_OPT_W-1){1'b0}}, 1'b1} << `DIG_OPT_DONE);
  // dedicated inputs bypass the user-side mux input stage
  assign m_in        = (pin_in & opts_r) | (user_in_r & ~opts_r);

  // sequencer next state; a low request always restarts
  always @* begin
    state_nxt = state_r;
    case (state_r)
      `DIG_ST_IDLE:   if (config_request_n) state_nxt = `DIG_ST_CONFIG;
      `DIG_ST_CONFIG: if (config_end) state_nxt = `DIG_ST_INIT;
      `DIG_ST_INIT:   if (init_tick && init_last) state_nxt = `DIG_ST_USER;
      `DIG_ST_USER:   state_nxt = `DIG_ST_USER;
      default:        state_nxt = `DIG_ST_IDLE;
    endcase
    if (!config_request_n) state_nxt = `DIG_ST_IDLE;
  end

  // init counter advances only on ticks
  always @* begin
    init_cnt_nxt = init_cnt_r;
    if (state_r != `DIG_ST_INIT)
      init_cnt_nxt = 16'h0000;
    else if (init_tick)
      init_cnt_nxt = init_cnt_r + 16'h0001;
  end

  // options latched from first frame, kept until reconfiguration
  always @* begin
    opts_nxt = opts_r;
    if (state_nxt == `DIG_ST_IDLE)
      opts_nxt = `DIG_OPT_RESET;
    else if (first_frame)
      opts_nxt = frame_opts;
  end

  // sequencer state and initialization counter
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r    <= `DIG_ST_IDLE;
      init_cnt_r <= 16'h0000;
    end else begin
      state_r    <= state_nxt;
      init_cnt_r <= init_cnt_nxt;
    end
  end

  // start-up clock edge finder; idles high like its pulled-up pin
  always @(posedge sys_clk or posedge reset) begin
    if (reset)
      stclk_sync_r <= `DIG_STCLK_IDLE;
    else
      stclk_sync_r <= {stclk_sync_r[1:0], pin_in[`DIG_OPT_STCLK]};
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset)
      opts_r <= `DIG_OPT_RESET;
    else
      opts_r <= opts_nxt;
  end

  // status levels; user mode waits for init-done release to reach the pin
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      in_config_r <= 1'b0;
      user_arm_r  <= 1'b0;
      user_mode_r <= 1'b0;
    end else begin
      in_config_r <= cfg_next;
      user_arm_r  <= user_state(state_r) && user_state(state_nxt);
      user_mode_r <= user_arm_r && user_state(state_nxt);
    end
  end

  // global override flags, one cycle after the pin level
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      io_tristate_r <= 1'b0;
      reg_clear_r   <= 1'b0;
    end else begin
      io_tristate_r <= override_low(opts_r[`DIG_OPT_OE], m_in[`DIG_OPT_OE]);
      reg_clear_r   <= override_low(opts_r[`DIG_OPT_CLR], m_in[`DIG_OPT_CLR]);
    end
  end

  genvar g;
  generate
    for (g = 0; g < `DIG_OPT_W; g = g + 1) begin : pin_g
      dig_pin_mux u_mux (
        .sys_clk      (sys_clk),
        .reset        (reset),
        .option_en    (opts_r[g]),
        .in_config    (pins_held),
        .pin_in       (pin_in[g]),
        .user_out     (user_out[g]),
        .user_oe      (user_oe[g]),
        .ded_out      (1'b0),
        .ded_oe       (ded_oe[g] & done_drive),
        .pin_out_r    (m_out[g]),
        .pin_oe_r     (m_oe[g]),
        .pin_pullup_r (m_pu[g]),
        .user_in_r    (m_in_unused[g])
      );
    end
  endgenerate

  // final pin stage; the enable override floats user i/o only
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pin_out_r    <= {`DIG_OPT_W{1'b0}};
      pin_oe_r     <= {`DIG_OPT_W{1'b0}};
      pin_pullup_r <= {`DIG_OPT_W{1'b1}};
    end else begin
      pin_out_r    <= m_out;
      pin_oe_r     <= m_oe & ~({`DIG_OPT_W{io_tristate_r}} & ~opts_r);
      pin_pullup_r <= m_pu;
    end
  end

  // user-side input stage, wiped while global clear is held
  always @(posedge sys_clk or posedge reset) begin
    if (reset)
      user_in_r <= {`DIG_OPT_W{1'b0}};
    else
      user_in_r <= reg_clear_r ? {`DIG_OPT_W{1'b0}} : m_in_unused;
  end
endmodule

// *** bench/dig_monitor.sv ***
// checker for init-done and global override pins
`timescale 1ns/1ps
module dig_monitor (
  input wire       sys_clk,
  input wire       reset,
  input wire       config_request_n,
  input wire [3:0] pin_in,
  input wire [3:0] pin_out_r,
  input wire [3:0] pin_oe_r,
  input wire [3:0] pin_pullup_r,
  input wire [3:0] opts_r,
  input wire       in_config_r,
  input wire       user_mode_r,
  input wire       io_tristate_r,
  input wire       reg_clear_r
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_held; !config_request_n [*3]; endsequence
  sequence s_cfg; (in_config_r && $stable(opts_r)) [*3]; endsequence
  sequence s_oe_low; (user_mode_r && opts_r[2] && !pin_in[2]) [*4]; endsequence
  sequence s_entry; $rose(user_mode_r); endsequence
  a_done_idle: assert property (s_held |-> !pin_oe_r[1])
    else $error("done driven in hold");
  a_done_drain: assert property (pin_oe_r[1] && opts_r[1] |-> !pin_out_r[1])
    else $error("done drives high");
  a_done_rise: assert property ($rose(opts_r[1]) && config_request_n |-> ##2 pin_oe_r[1])
    else $error("done not low");
  a_user_entry: assert property (s_entry |-> !in_config_r && !(opts_r[1] && pin_oe_r[1]))
    else $error("user with done low");
  a_cfg_pullup: assert property (s_cfg |->
    (pin_oe_r & ~opts_r) == 4'h0 && (pin_pullup_r | opts_r) == 4'hf)
    else $error("user pin not floated");
  a_oe_force: assert property (s_oe_low |-> io_tristate_r && pin_oe_r == 4'h0)
    else $error("pins not floated");
  a_clr_force: assert property ((opts_r[3] && !pin_in[3]) [*2] |-> reg_clear_r)
    else $error("clear missing");
  a_opts_hold: assert property (user_mode_r && config_request_n |=> $stable(opts_r))
    else $error("options changed");
endmodule
bind dig_ctrl dig_monitor i_dig_monitor (.sys_clk(sys_clk), .reset(reset),
  .config_request_n(config_request_n), .pin_in(pin_in), .pin_out_r(pin_out_r),
  .pin_oe_r(pin_oe_r), .pin_pullup_r(pin_pullup_r), .opts_r(opts_r),
  .in_config_r(in_config_r), .user_mode_r(user_mode_r),
  .io_tristate_r(io_tristate_r), .reg_clear_r(reg_clear_r));

// *** bench/dig_board.sv ***
// board model: line levels and init-done edge monitor
`timescale 1ns/1ps
module dig_board (
  input  wire       sys_clk,
  input  wire [3:0] pin_out_r,
  input  wire [3:0] pin_oe_r,
  input  wire [3:0] ext_drv,
  output wire [3:0] pin_lvl,
  output reg  [7:0] done_rises = 8'h0
);
  reg last_r = 1'b1;
  // released lines, init-done included, follow board drive ext_drv
  assign pin_lvl = (pin_oe_r & pin_out_r) | (~pin_oe_r & ext_drv);
  always @(posedge sys_clk) begin
    last_r <= pin_lvl[1];
    if (pin_lvl[1] && !last_r) done_rises <= done_rises + 8'h1;
  end
endmodule

// *** bench/tb.sv ***
// bench for init and global control pins
`timescale 1ns/1ps
module tb;
  localparam N = 4;
  reg sys_clk = 1'b0, reset = 1'b1, config_request_n = 1'b0;
  reg frame_valid = 1'b0, frame_first = 1'b0, config_end = 1'b0;
  reg [3:0] frame_opts = 4'h0, user_out = 4'h5, ext_drv = 4'hf;
  wire [3:0] pin_lvl, pin_out_r, pin_oe_r, pin_pullup_r, user_in_r, opts_r;
  wire in_config_r, user_mode_r, io_tristate_r, reg_clear_r;
  wire [7:0] done_rises;
  integer bad_count = 0, n_tests = 0, i, r;
  always #4 sys_clk = ~sys_clk;
  dig_ctrl #(.INIT_CYC(N)) i_dig_ctrl (.sys_clk(sys_clk), .reset(reset),
    .config_request_n(config_request_n), .frame_valid(frame_valid),
    .frame_first(frame_first), .frame_opts(frame_opts), .config_end(config_end),
    .pin_in(pin_lvl), .user_out(user_out), .user_oe(4'hf), .pin_out_r(pin_out_r),
    .pin_oe_r(pin_oe_r), .pin_pullup_r(pin_pullup_r), .user_in_r(user_in_r),
    .opts_r(opts_r), .in_config_r(in_config_r), .user_mode_r(user_mode_r),
    .io_tristate_r(io_tristate_r), .reg_clear_r(reg_clear_r));
  dig_board i_dig_board (.sys_clk(sys_clk), .pin_out_r(pin_out_r), .pin_oe_r(pin_oe_r),
    .ext_drv(ext_drv), .pin_lvl(pin_lvl), .done_rises(done_rises));
  task cyc(input integer n);
    repeat (n) @(negedge sys_clk);
  endtask
  task check(input [31:0] seen, input [31:0] exp, input [63:0] what);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("Error %0s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task cfg(input [3:0] o);
    config_request_n = 1'b0;
    cyc(3);
    check(pin_oe_r[1], 0, "done_oe");
    config_request_n = 1'b1;
    cyc(1);
    frame_valid = 1'b1;
    frame_first = 1'b1;
    frame_opts = o;
    cyc(1);
    frame_valid = 1'b0;
    frame_first = 1'b0;
    cyc(4);
    check(pin_lvl[1], !o[1], "done_lvl");
    check(opts_r, o, "opts");
    check(pin_oe_r & ~o, 0, "cfg_oe");
    check(in_config_r, 1, "in_cfg");
    config_end = 1'b1;
    cyc(1);
    config_end = 1'b0;
  endtask
  task wait_um;
    for (i = 0; user_mode_r !== 1'b1 && i < 40; i = i + 1) cyc(1);
    check(user_mode_r, 1, "user");
    cyc(3);
  endtask
  task t_done;
    cfg(4'h2);
    r = done_rises;
    wait_um;
    check(done_rises, r + 1, "rises");
    check(pin_oe_r[1], 0, "done_rel");
  endtask
  task t_clk;
    ext_drv[0] = 1'b0;
    cfg(4'h3);
    cyc(40);
    check(user_mode_r, 0, "stall");
    repeat (N) begin
      ext_drv[0] = 1'b1;
      cyc(2);
      ext_drv[0] = 1'b0;
      cyc(2);
    end
    wait_um;
  endtask
  task t_ovr;
    cfg(4'hc);
    wait_um;
    check(pin_oe_r, 4'h3, "oe_on");
    ext_drv[2] = 1'b0;
    cyc(4);
    check(pin_oe_r, 0, "oe_off");
    ext_drv[2] = 1'b1;
    ext_drv[3] = 1'b0;
    cyc(4);
    check(user_in_r, 0, "clr");
    ext_drv[3] = 1'b1;
    cyc(4);
    check(user_in_r & 4'h3, 4'h1, "uin");
  endtask
  task conclude;
    $display("tests %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    cyc(16);
    reset = 1'b0;
    check(pin_pullup_r, 4'hf, "pullup");
    t_done;
    t_clk;
    t_ovr;
    conclude;
  end
  initial begin
    #24000;
    bad_count = bad_count + 1;
    conclude;
  end
endmodule
